// ==== common/rtc_alarm_cfg.svh ====
// Overview of operation
// R1: Compare byte: BCD value, bit7 include; zero excluded
// R2: Fire when time advances into full equality
// R3: Each match sets the alarm-0 status flag; the code sets it only when an event fires (enabled, and armed unless repeat)
// R4: Host must set enable bit 5 first
// R5: Mode bit zero: single event, fires once
// R6: Mode bit 7 one: pulse every match
// R7: Seconds-only at thirty: once per minute
// R8: Repeat continues although flag never cleared
// R9: Compare value bits only, AND included fields
`ifndef RTC_ALARM_CFG_SVH
`define RTC_ALARM_CFG_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ADDR_SECONDS_CMP 3'h0
`define ADDR_MINUTES_CMP 3'h1
`define ADDR_HOURS_CMP 3'h2
`define ADDR_DATE_CMP 3'h3
`define ADDR_MONTH_CMP 3'h4
`define ADDR_WEEKDAY_CMP 3'h5
`define ADDR_ALARM_CTRL 3'h6
`define ADDR_STATUS 3'h7

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define INCLUDE_BIT 7
`define VALUE_MSB 6
`define ENABLE_BIT 5
`define REPEAT_BIT 7
`define FLAG_BIT 0

// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define COMPARE_RST 8'h00
`define CTRL_RST 8'h00
`define FIELD_COUNT 6

`endif

// ==== common/rtc_alarm_pkg.sv ====
`default_nettype none
package rtc_alarm_pkg;

  // Running time, BCD per field
  typedef struct packed {
    logic [7:0] weekday;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rtc_time_type;

  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // Single-event arming state
  typedef enum logic [1:0] {
    ARM_READY = 2'b01,
    ARM_SPENT = 2'b10
  } arm_state_type;

endpackage : rtc_alarm_pkg
`default_nettype wire

// ==== hw/alarm_field_match.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_cfg.svh"

module alarm_field_match
(
  input wire logic [7:0] compare_i,
  input wire logic [7:0] count_i,
  output logic include_o,
  output logic equal_o
);

  // Include flag and value-only equality
  assign include_o = compare_i[`INCLUDE_BIT]; // R1
  assign equal_o = (compare_i[`VALUE_MSB:0] == count_i[`VALUE_MSB:0]); // R9

endmodule : alarm_field_match
`default_nettype wire

// ==== hw/rtc_alarm0_match_logic.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_cfg.svh"

module rtc_alarm0_match_logic
  import rtc_alarm_pkg::*;
#(
  parameter int FIELDS = `FIELD_COUNT
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic tick_i,
  input wire rtc_time_type time_i,
  input wire reg_req_type reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic alarm0_event_o,
  output logic alarm0_flag_o
);

  // ------------------------------------------------------------
  // Field comparison
  // ------------------------------------------------------------
  logic [FIELDS-1:0][7:0] now_bytes;
  logic [FIELDS-1:0][7:0] cmp_r;
  logic [FIELDS-1:0][7:0] cmp_nxt;
  logic [FIELDS-1:0] incl;
  logic [FIELDS-1:0] eq;
  logic match;

  // Seconds at index zero
  assign now_bytes = {time_i.weekday, time_i.month, time_i.date, time_i.hours, time_i.minutes, time_i.seconds};

  // One comparator per field
  generate
    for (genvar g = 0; g < FIELDS; g++)
    begin : g_field
      alarm_field_match u_match
      (
        .compare_i(cmp_r[g]),
        .count_i(now_bytes[g]),
        .include_o(incl[g]),
        .equal_o(eq[g])
      );
    end
  endgenerate

  // Included fields ANDed; none included never matches
  assign match = (|incl) & (&(eq | ~incl)); // R1 R7 R9

  // ------------------------------------------------------------
  // Control, arming and status
  // ------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic tick_d_r;
  logic tick_d_nxt;
  logic match_last_r;
  logic match_last_nxt;
  logic event_r;
  logic event_nxt;
  logic flag_r;
  logic flag_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  arm_state_type state_r;
  arm_state_type state_nxt;
  logic enabled;
  logic repeat_mode;
  logic entered;
  logic fire;
  logic cfg_write;
  logic stat_read;

  assign enabled = ctrl_r[`ENABLE_BIT];
  assign repeat_mode = ctrl_r[`REPEAT_BIT];
  // Time counters settle the cycle after the tick
  assign entered = tick_d_r & match & ~match_last_r; // R2
  assign fire = entered & enabled & (repeat_mode | (state_r == ARM_READY)); // R4 R5 R6 R8
  assign cfg_write = reg_req_i.wr & (reg_req_i.addr != `ADDR_STATUS);
  assign stat_read = reg_req_i.rd & (reg_req_i.addr == `ADDR_STATUS);

  // Next-state computation
  always_comb
  begin
    cmp_nxt = cmp_r;
    ctrl_nxt = ctrl_r;
    tick_d_nxt = tick_i;
    match_last_nxt = tick_d_r ? match : match_last_r;
    event_nxt = fire;
    flag_nxt = flag_r;
    rdata_nxt = rdata_r;
    state_nxt = state_r;
    // Register writes
    if (reg_req_i.wr)
    begin
      if (reg_req_i.addr == `ADDR_ALARM_CTRL)
      begin
        ctrl_nxt = reg_req_i.wdata;
      end
      else if (reg_req_i.addr != `ADDR_STATUS)
      begin
        cmp_nxt[reg_req_i.addr] = reg_req_i.wdata;
      end
    end
    // Reprogramming rearms; a single event spends the alarm
    unique case (state_r)
      ARM_READY:
      begin
        if (fire && !repeat_mode && !cfg_write)
        begin
          state_nxt = ARM_SPENT; // R5
        end
      end
      ARM_SPENT:
      begin
        if (cfg_write)
        begin
          state_nxt = ARM_READY;
        end
      end
    endcase
    // Register reads
    if (reg_req_i.rd)
    begin
      if (reg_req_i.addr == `ADDR_ALARM_CTRL)
      begin
        rdata_nxt = ctrl_r;
      end
      else if (reg_req_i.addr == `ADDR_STATUS)
      begin
        rdata_nxt = 8'h00;
        rdata_nxt[`FLAG_BIT] = flag_r;
      end
      else
      begin
        rdata_nxt = cmp_r[reg_req_i.addr];
      end
    end
    // Read clears the flag, a new event wins
    if (stat_read)
    begin
      flag_nxt = 1'b0;
    end
    if (fire)
    begin
      flag_nxt = 1'b1; // R3 R8
    end
  end

  // State registers
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cmp_r <= {FIELDS{`COMPARE_RST}};
      ctrl_r <= `CTRL_RST;
      tick_d_r <= 1'b0;
      match_last_r <= 1'b0;
      event_r <= 1'b0;
      flag_r <= 1'b0;
      rdata_r <= 8'h00;
      state_r <= ARM_READY;
    end
    else
    begin
      cmp_r <= cmp_nxt;
      ctrl_r <= ctrl_nxt;
      tick_d_r <= tick_d_nxt;
      match_last_r <= match_last_nxt;
      event_r <= event_nxt;
      flag_r <= flag_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign alarm0_event_o = event_r;
  assign alarm0_flag_o = flag_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  AST_NO_INCLUDE_SILENT: assert property (event_r |-> $past(|incl)) // R1
    else $error("Event with no field included");
  AST_EVENT_ON_ENTRY: assert property (event_r |-> $past(tick_d_r) && !$past(match_last_r)) // R2
    else $error("Event not at entry into equality");
  AST_FLAG_WITH_EVENT: assert property (event_r |-> flag_r) // R3
    else $error("Flag not set on event");
  AST_NEEDS_ENABLE: assert property (event_r |-> $past(ctrl_r[`ENABLE_BIT])) // R4
    else $error("Event while alarm disabled");
  AST_SINGLE_SPENDS: assert property (event_r && !$past(repeat_mode) && !$past(cfg_write) |-> // R5
    state_r == ARM_SPENT)
    else $error("Single event did not disarm");
  AST_SPENT_QUIET: assert property ($past(state_r) == ARM_SPENT && !$past(repeat_mode) |-> !event_r) // R5
    else $error("Spent single alarm fired again");
  AST_REPEAT_FIRES: assert property (entered && enabled && repeat_mode |=> event_r) // R6 R8
    else $error("Repeat mode missed a match");
  AST_SECONDS_THIRTY: assert property (tick_d_r && enabled && repeat_mode && !match_last_r // R7
    && cmp_r == {40'h0, 8'hb0} && time_i.seconds == 8'h30 |=> event_r)
    else $error("No event at seconds thirty");
  AST_VALUE_MATCH: assert property (event_r |-> $past(match)) // R9
    else $error("Event without field match");
  AST_READ_CLEARS: assert property (stat_read && !fire |=> !flag_r)
    else $error("Status read did not clear flag");
  // Event pulse and status readback
  AST_ONE_EVENT_PER_TICK: assert property (event_r |=> !event_r) // R2
    else $error("Event lasted more than one cycle");
  AST_STATUS_READBACK: assert property (stat_read |=> reg_rdata_o[`FLAG_BIT] == $past(flag_r)) // R3
    else $error("Status read returned wrong flag");

  COV_SINGLE: cover property (event_r && state_r == ARM_SPENT);
  COV_REPEAT: cover property (event_r && repeat_mode ##[6:60] event_r);
  COV_REPEAT_FLAG_HELD: cover property (event_r && $past(flag_r) && repeat_mode);
  COV_READ_CLEAR: cover property (flag_r && stat_read ##1 !flag_r);

endmodule : rtc_alarm0_match_logic
`default_nettype wire

// ==== verif/rtc_alarm0_match_logic_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm0_match_logic_bench
  import rtc_alarm_pkg::*;
;
  logic clk, srst, tick, ev, flag, spent, prev, flag_exp;
  logic [7:0] rdata, ctrl, cmp [6];
  logic [31:0] r;
  rtc_time_type tm;
  reg_req_type req;
  int bad_count = 0;
  int check_count = 0;
  int seed = 83;

  rtc_alarm0_match_logic #(.FIELDS(6)) dut (.clk_i(clk), .srst_i(srst), .tick_i(tick), .time_i(tm),
    .reg_req_i(req), .reg_rdata_o(rdata), .alarm0_event_o(ev), .alarm0_flag_o(flag));
  rtc_host_model host (.clk_i(clk), .rdata_i(rdata), .req_o(req));

  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  initial clk = 0;
  always #50 clk = ~clk;

  function automatic rtc_time_type t1(input logic [7:0] mi, input logic [7:0] s);
    return {8'h05, 8'h01, 8'h01, 8'h11, mi, s};
  endfunction : t1

  // Expected match of included fields
  function automatic logic matchf(input rtc_time_type t);
    logic [47:0] v;
    logic any;
    logic all;
    v = t;
    any = 0;
    all = 1;
    for (int i = 0; i < 6; i++)
    begin
      if (cmp[i][7])
      begin
        any = 1;
        if (cmp[i][6:0] != v[8*i +: 7]) all = 0;
      end
    end
    return any & all;
  endfunction : matchf

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (a < 3'h6) cmp[a] = d;
    if (a == 3'h6) ctrl = d;
    if (a != 3'h7) spent = 0;
  endtask : wreg

  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
    if (a == 3'h7) flag_exp = 0;
  endtask : rreg

  // One tick with a new time, events counted
  task automatic adv(input rtc_time_type t);
    logic m;
    logic fire;
    logic [7:0] n;
    m = matchf(t);
    fire = ctrl[5] & m & !prev & (ctrl[7] | !spent);
    prev = m;
    if (fire & !ctrl[7]) spent = 1;
    if (fire) flag_exp = 1;
    n = 0;
    @(posedge clk);
    #1 tick = 1;
    @(posedge clk);
    #1 tick = 0;
    tm = t;
    repeat (4)
    begin
      @(posedge clk);
      #1 n += ev;
    end
    chk(n, {7'h0, fire});
    chk({7'h0, flag}, {7'h0, flag_exp});
  endtask : adv

  task automatic report_and_stop;
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    tick = 0;
    tm = '0;
    srst = 1;
    ctrl = 0;
    spent = 0;
    prev = 0;
    flag_exp = 0;
    cmp = '{default: 8'h00};
    repeat (5) @(posedge clk);
    #1 srst = 0;
    for (int i = 0; i < 8; i++) rreg(3'(i), 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      r = $random(seed);
      wreg(3'(i), r[7:0]);
      rreg(3'(i), r[7:0]);
    end
    wreg(3'h7, 8'hff);
    rreg(3'h7, 8'h00);
    // Single event on an exact date and time
    wreg(3'h0, 8'h00);
    wreg(3'h1, 8'hb0);
    wreg(3'h2, 8'h91);
    wreg(3'h3, 8'h81);
    wreg(3'h4, 8'h81);
    wreg(3'h5, 8'h00);
    wreg(3'h6, 8'h20);
    adv(t1(8'h29, 8'h59));
    adv(t1(8'h30, 8'h00));
    adv(t1(8'h30, 8'h01));
    rreg(3'h7, 8'h01);
    rreg(3'h7, 8'h00);
    adv(t1(8'h29, 8'h59));
    adv(t1(8'h30, 8'h00));
    // Enable off blocks the alarm
    wreg(3'h6, 8'h00);
    adv(t1(8'h29, 8'h59));
    adv(t1(8'h30, 8'h00));
    // Repeating pulse at thirty seconds, flag never read
    for (int i = 1; i < 6; i++) wreg(3'(i), 8'h00);
    wreg(3'h0, 8'hb0);
    wreg(3'h6, 8'ha0);
    adv(t1(8'h44, 8'h29));
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      adv(t1({4'h4, 1'b0, r[5:3]}, r[0] ? 8'h30 : 8'h31));
    end
    // Value bits without include bit take no part
    wreg(3'h0, 8'h30);
    rreg(3'h7, {7'h0, flag_exp});
    adv(t1(8'h45, 8'h29));
    adv(t1(8'h45, 8'h30));
    // Mid-run reset clears compares, control and flag
    @(posedge clk);
    #1 srst = 1;
    repeat (2) @(posedge clk);
    #1 srst = 0;
    ctrl = 0;
    spent = 0;
    prev = 0;
    flag_exp = 0;
    cmp = '{default: 8'h00};
    for (int i = 0; i < 8; i++) rreg(3'(i), 8'h00);
    report_and_stop();
  end

  // Watchdog against a hang
  initial
  begin
    #1000000;
    bad_count++;
    report_and_stop();
  end
endmodule : rtc_alarm0_match_logic_bench
`default_nettype wire

// ==== verif/rtc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model
  import rtc_alarm_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output var reg_req_type req_o
);
  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  initial req_o = '0;

  // One write, then idle with scrambled data
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 req_o = {2'b10, a, d};
    @(posedge clk_i);
    #1 req_o = {2'b00, ~a, ~d};
  endtask : wr

  // One read, data taken the cycle after
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1 req_o = {2'b01, a, 8'h5a};
    @(posedge clk_i);
    #1 req_o = {2'b00, ~a, 8'ha5};
    d = rdata_i;
  endtask : rd
endmodule : rtc_host_model
`default_nettype wire
